// ### shared/ciac_defines.vh
/*
 Constants for the control input assignment checker: register offsets,
 field positions, reset values, function codes and timing counts.
 Assumes a 250 MHz pclk and a 12-bit APB byte address.
*/
`ifndef CIAC_DEFINES_VH
`define CIAC_DEFINES_VH
// ==========================================
// Register offsets
`define CIAC_OFS_CFG 12'h000
`define CIAC_OFS_STAT 12'h004
`define CIAC_OFS_MASK 12'h008
`define CIAC_OFS_FUNC 12'h00C
`define CIAC_OFS_PINS 12'h010
`define CIAC_OFS_SEL0 12'h020
`define CIAC_OFS_SEL7 12'h03C
// ==========================================
// Configuration fields
`define CIAC_CFG_RC_LSB 0
`define CIAC_CFG_TI_LSB 2
`define CIAC_CFG_BRAKE 4
`define CIAC_CFG_APPLY 5
`define CIAC_CFG_HOMETRIG 6
`define CIAC_CFG_MODE_LSB 8
`define CIAC_CFG_RST 11'h000
`define CIAC_SEL_RST 24'h00_0000
`define CIAC_SEL_MAX 24'hFF_FFFF
// ==========================================
// Alarm status bits
`define CIAC_ST_OVL1 0
`define CIAC_ST_OVL2 1
`define CIAC_ST_FNUM1 2
`define CIAC_ST_FNUM2 3
`define CIAC_ST_LATCH 4
`define CIAC_ST_TRAVEL 5
// ==========================================
// Function codes, contact logic and settings
`define CIAC_NC_BIT 7
`define CIAC_FC_PTI 7'h01
`define CIAC_FC_NTI 7'h02
`define CIAC_FC_XSON 7'h03
`define CIAC_FC_FALM 7'h14
`define CIAC_FC_BRK 7'h16
`define CIAC_FC_LAT1 7'h20
`define CIAC_FC_LAT2 7'h21
`define CIAC_FC_HOME 7'h22
`define CIAC_FC_RSTOP 7'h23
`define CIAC_FC_RET 7'h27
`define CIAC_FC_LAT3 7'h2B
`define CIAC_FC_MON1 7'h2E
`define CIAC_FC_MON2 7'h2F
`define CIAC_FC_MON3 7'h30
`define CIAC_FC_MON4 7'h31
`define CIAC_FC_MON5 7'h32
`define CIAC_TI_DISABLED 2'd1
`define CIAC_BRAKE_ON 1'b1
// Fast functions: travel inhibits 0,1, latches 5,6,10, home 7
`define CIAC_FAST_LATCH 16'h0460
`define CIAC_FAST_HOME 16'h0083
// ==========================================
// Timing
`define CIAC_CLK_PERIOD_PS 4000
`define CIAC_BASE_PERIOD_US 250
`endif

// ### verilog/ciac_top.v
/*
 Control input assignment checker: samples eight input pins, maps them
 onto input functions per control mode and checks the mapping.
 Assumes synchronous pins, an APB master on pclk and a drive core that
 supplies the forced control mode.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ciac_defines.vh"

// Notes on behaviour
// - Inputs sampled every 250us, 500us, 1ms or 2ms by a 2-bit setting.
// - Latch inputs, and travel/home inputs as home trigger, bypass the read cycle.
// - One function on two pins in a mode raises both overlap alarms.
// - A disabled pin affects neither function states nor network status.
// - A function on different pins in different modes raises an overlap alarm.
// - A shared function with differing contact logic raises a function alarm.
// - Monitor inputs share status bits with partners; both assigned raises overlap alarms.
// - A forced control mode overrides the commanded mode for input mapping.
// - Brake input needs brake setting 1 and assignment in every mode.
// - Forced alarm, retract and servo-on must be assigned in all modes.
// - Travel inhibit as home trigger needs travel inhibit setting 1, else alarm.
// - Latch compensation pins must match in all modes, else latch alarm.
// - Each pin selection holds 0 to 0xFFFFFF, same layout for every pin.
// - Bit 7 selects normally-closed logic; code zero disables the pin.
module ciac_top #(
    parameter BASE_CYCLES = (`CIAC_BASE_PERIOD_US * 1000 * 1000) / `CIAC_CLK_PERIOD_PS
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [7:0] pin_in,
    input wire force_mode_en,
    input wire [1:0] force_mode,
    output reg [15:0] func_state,
    output reg [4:0] net_status,
    output reg irq
);
    // ==========================================
    // Storage
    reg [10:0] cfg;
    reg [5:0] alarm;
    reg [5:0] mask;
    reg [23:0] sel [0:7];
    reg check_go;
    reg [15:0] base_cnt;
    reg [2:0] sub_cnt;
    reg tick;
    wire [191:0] sel_flat;
    wire [1:0] mode;
    wire wr;
    genvar gi;

    // Flatten the selection table so functions can scan it
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_flat
            assign sel_flat[gi*24 +: 24] = sel[gi];
        end
    endgenerate

    // Forced mode from the drive core wins over the commanded one
    assign mode = force_mode_en ? force_mode : cfg[`CIAC_CFG_MODE_LSB +: 2];
    assign wr = psel & penable & pready & pwrite;

    // ==========================================
    // Helpers
    function [6:0] func_code;
        input [3:0] k;
        begin
            case (k)
                4'd0: func_code = `CIAC_FC_PTI;
                4'd1: func_code = `CIAC_FC_NTI;
                4'd2: func_code = `CIAC_FC_XSON;
                4'd3: func_code = `CIAC_FC_FALM;
                4'd4: func_code = `CIAC_FC_BRK;
                4'd5: func_code = `CIAC_FC_LAT1;
                4'd6: func_code = `CIAC_FC_LAT2;
                4'd7: func_code = `CIAC_FC_HOME;
                4'd8: func_code = `CIAC_FC_RSTOP;
                4'd9: func_code = `CIAC_FC_RET;
                4'd10: func_code = `CIAC_FC_LAT3;
                4'd11: func_code = `CIAC_FC_MON1;
                4'd12: func_code = `CIAC_FC_MON2;
                4'd13: func_code = `CIAC_FC_MON3;
                4'd14: func_code = `CIAC_FC_MON4;
                default: func_code = `CIAC_FC_MON5;
            endcase
        end
    endfunction

    // True when code c sits on any pin in mode m
    function pres;
        input [191:0] f;
        input [1:0] m;
        input [6:0] c;
        integer p;
        begin
            pres = 1'b0;
            for (p = 0; p < 8; p = p + 1) begin
                if (f[p*24 + m*8 +: 7] == c) begin
                    pres = 1'b1;
                end
            end
        end
    endfunction

    // Number of modes (0..3) that carry code c
    function [1:0] modes_with;
        input [191:0] f;
        input [6:0] c;
        begin
            modes_with = {1'b0, pres(f, 2'd0, c)} + {1'b0, pres(f, 2'd1, c)} + {1'b0, pres(f, 2'd2, c)};
        end
    endfunction

    // ==========================================
    // Live mapping of pins to functions
    reg [15:0] live;
    reg [7:0] cb;
    integer lk;
    integer lp;
    always @* begin
        live = 16'h0000;
        cb = 8'h00;
        for (lk = 0; lk < 16; lk = lk + 1) begin
            for (lp = 0; lp < 8; lp = lp + 1) begin
                cb = sel_flat[lp*24 + mode*8 +: 8];
                // Code zero never matches a function, so disabled pins drop out
                if (cb[6:0] == func_code(lk[3:0])) begin
                    live[lk] = live[lk] | (pin_in[lp] ^ cb[`CIAC_NC_BIT]);
                end
            end
        end
    end

    // ==========================================
    // Assignment checks
    reg e_dup, e_xpin, e_logic, e_part, e_latch, e_trav;
    reg [7:0] ca, cc;
    reg [1:0] nm;
    integer m, n, i, j;
    always @* begin
        e_dup = 1'b0;
        e_xpin = 1'b0;
        e_logic = 1'b0;
        e_part = 1'b0;
        e_latch = 1'b0;
        e_trav = 1'b0;
        ca = 8'h00;
        cc = 8'h00;
        nm = 2'd0;
        for (m = 0; m < 3; m = m + 1) begin
            for (i = 0; i < 8; i = i + 1) begin
                ca = sel_flat[i*24 + m*8 +: 8];
                for (n = 0; n < 3; n = n + 1) begin
                    for (j = 0; j < 8; j = j + 1) begin
                        cc = sel_flat[j*24 + n*8 +: 8];
                        if (ca[6:0] != 7'h00 && ca[6:0] == cc[6:0]) begin
                            if (m == n && i < j) begin
                                e_dup = 1'b1;
                            end
                            if (m != n && i != j) begin
                                e_xpin = 1'b1;
                            end
                            if (m != n && i == j && ca[7] != cc[7]) begin
                                e_logic = 1'b1;
                            end
                        end
                    end
                end
            end
            // Monitor inputs collide with partners on one status bit
            nm = m[1:0];
            if ((pres(sel_flat, nm, `CIAC_FC_MON1) && pres(sel_flat, nm, `CIAC_FC_LAT1)) ||
                (pres(sel_flat, nm, `CIAC_FC_MON2) &&
                 (pres(sel_flat, nm, `CIAC_FC_LAT2) || pres(sel_flat, nm, `CIAC_FC_RET))) ||
                (pres(sel_flat, nm, `CIAC_FC_MON3) &&
                 (pres(sel_flat, nm, `CIAC_FC_LAT3) || pres(sel_flat, nm, `CIAC_FC_RSTOP))) ||
                (pres(sel_flat, nm, `CIAC_FC_MON4) && pres(sel_flat, nm, `CIAC_FC_XSON)) ||
                (pres(sel_flat, nm, `CIAC_FC_MON5) && pres(sel_flat, nm, `CIAC_FC_FALM))) begin
                e_dup = 1'b1;
            end
        end
        // Partial assignment across modes
        nm = modes_with(sel_flat, `CIAC_FC_BRK);
        if (nm == 2'd1 || nm == 2'd2) begin
            e_part = 1'b1;
        end
        if (nm != 2'd0 && cfg[`CIAC_CFG_BRAKE] != `CIAC_BRAKE_ON) begin
            e_logic = 1'b1;
        end
        for (i = 0; i < 3; i = i + 1) begin
            nm = modes_with(sel_flat, (i == 0) ? `CIAC_FC_FALM : ((i == 1) ? `CIAC_FC_RET : `CIAC_FC_XSON));
            if (nm == 2'd1 || nm == 2'd2) begin
                e_part = 1'b1;
            end
        end
        // Latch compensation pins must be identical in every mode
        for (i = 4; i < 7; i = i + 1) begin
            if (sel_flat[i*24 +: 8] != sel_flat[i*24+8 +: 8] ||
                sel_flat[i*24 +: 8] != sel_flat[i*24+16 +: 8]) begin
                e_latch = 1'b1;
            end
        end
        if (cfg[`CIAC_CFG_HOMETRIG] && cfg[`CIAC_CFG_TI_LSB +: 2] != `CIAC_TI_DISABLED &&
            (modes_with(sel_flat, `CIAC_FC_PTI) != 2'd0 || modes_with(sel_flat, `CIAC_FC_NTI) != 2'd0)) begin
            e_trav = 1'b1;
        end
    end

    wire [5:0] found = {e_trav, e_latch, e_part, e_logic, e_dup, e_dup | e_xpin};

    // ==========================================
    // Read cycle divider: base tick times 1, 2, 4 or 8
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_cnt <= 16'h0000;
            sub_cnt <= 3'd0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (base_cnt == BASE_CYCLES[15:0] - 16'h0001) begin
                base_cnt <= 16'h0000;
                // Sub count wraps at 2^code - 1
                if (sub_cnt >= ((3'd1 << cfg[`CIAC_CFG_RC_LSB +: 2]) - 3'd1)) begin
                    sub_cnt <= 3'd0;
                    tick <= 1'b1;
                end else begin
                    sub_cnt <= sub_cnt + 3'd1;
                end
            end else begin
                base_cnt <= base_cnt + 16'h0001;
            end
        end
    end

    // ==========================================
    // Function states and network status word
    wire [15:0] fast = `CIAC_FAST_LATCH | (cfg[`CIAC_CFG_HOMETRIG] ? `CIAC_FAST_HOME : 16'h0000);
    wire [15:0] upd = tick ? 16'hFFFF : fast;
    wire [15:0] next_func = (func_state & ~upd) | (live & upd);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func_state <= 16'h0000;
            net_status <= 5'h00;
        end else begin
            func_state <= next_func;
            // Shared bits: a monitor and its partner are never both assigned once checks pass
            net_status <= {next_func[15] | next_func[3], next_func[14] | next_func[2],
                           next_func[13] | next_func[10] | next_func[8],
                           next_func[12] | next_func[6] | next_func[9],
                           next_func[11] | next_func[5]};
        end
    end

    // ==========================================
    // APB slave: one wait state, answer registered
    integer w;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            cfg <= `CIAC_CFG_RST;
            mask <= 6'h00;
            check_go <= 1'b0;
            for (w = 0; w < 8; w = w + 1) begin
                sel[w] <= `CIAC_SEL_RST;
            end
        end else begin
            pready <= psel & penable & ~pready;
            check_go <= 1'b0;
            if (psel & penable & ~pready) begin
                pslverr <= 1'b0;
                prdata <= 32'h0000_0000;
                if (paddr == `CIAC_OFS_CFG) begin
                    prdata <= {21'h00_0000, cfg};
                end else if (paddr == `CIAC_OFS_STAT) begin
                    prdata <= {26'h000_0000, alarm};
                end else if (paddr == `CIAC_OFS_MASK) begin
                    prdata <= {26'h000_0000, mask};
                end else if (paddr == `CIAC_OFS_FUNC) begin
                    prdata <= {11'h000, net_status, func_state};
                end else if (paddr == `CIAC_OFS_PINS) begin
                    prdata <= {24'h00_0000, pin_in};
                end else if (paddr >= `CIAC_OFS_SEL0 && paddr <= `CIAC_OFS_SEL7 && paddr[1:0] == 2'b00) begin
                    prdata <= {8'h00, sel[paddr[4:2]]};
                end else begin
                    pslverr <= 1'b1;
                end
            end
            if (wr) begin
                if (paddr == `CIAC_OFS_CFG) begin
                    // Apply bit is a strobe and reads back as zero
                    cfg <= pwdata[10:0] & ~(11'h001 << `CIAC_CFG_APPLY);
                    check_go <= pwdata[`CIAC_CFG_APPLY];
                end else if (paddr == `CIAC_OFS_MASK) begin
                    mask <= pwdata[5:0];
                end else if (paddr >= `CIAC_OFS_SEL0 && paddr <= `CIAC_OFS_SEL7 && paddr[1:0] == 2'b00) begin
                    sel[paddr[4:2]] <= pwdata[23:0] & `CIAC_SEL_MAX;
                end
            end
        end
    end

    // ==========================================
    // Sticky alarms: set on apply, write one to clear, set wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm <= 6'h00;
            irq <= 1'b0;
        end else begin
            alarm <= (alarm & ~((wr && paddr == `CIAC_OFS_STAT) ? pwdata[5:0] : 6'h00))
                     | (check_go ? found : 6'h00);
            irq <= |(alarm & mask);
        end
    end
endmodule
`default_nettype wire

// ### verilog/ciac_unused_guard.v
`timescale 1ns/1ps

// ### verification/ciac_chk.sv
/*
 Port checker for ciac_top, bound from the bench top.
 Assumes one pclk domain, presetn its asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ciac_chk #(
    parameter BASE_CYCLES = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] func_state,
    input wire logic [4:0] net_status,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================
    // Decode of finished transfers
    wire logic done = psel && penable && pready;
    wire logic mapped = paddr[1:0] == 2'h0 && (paddr <= 12'h010 || (paddr >= 12'h020 && paddr <= 12'h03C));
    wire logic apply_wr = done && pwrite && paddr == 12'h000 && pwdata[5];
    wire logic irq_wr = done && pwrite && (paddr == 12'h004 || paddr == 12'h008);
    wire logic rd_ok = pready && !pwrite;
    logic [5:0] mask_sh;
    // Mask shadow, since irq may only follow unmasked alarms
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_sh <= 6'h00;
        end else if (done && pwrite && paddr == 12'h008) begin
            mask_sh <= pwdata[5:0];
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    // ==========================================
    // Bus and status assertions
    pready_wait_a: assert property (s_setup ##1 s_access |=> pready) else $error("pready late");
    pready_pulse_a: assert property (pready |=> !pready) else $error("pready too wide");
    slverr_map_a: assert property (pready |-> pslverr == !mapped && (!pslverr || prdata == 32'h0))
        else $error("bad error response");
    sel_width_a: assert property (rd_ok && paddr[11:5] == 7'h01 |-> prdata[31:24] == 8'h00)
        else $error("selection wider than 24 bits");
    func_read_a: assert property (rd_ok && paddr == 12'h00C |-> prdata == {11'h0, $past(net_status),
        $past(func_state)}) else $error("function word differs");
    net_pack_a: assert property (net_status == {func_state[15] | func_state[3],
        func_state[14] | func_state[2], func_state[13] | func_state[10] | func_state[8],
        func_state[12] | func_state[6] | func_state[9], func_state[11] | func_state[5]})
        else $error("network status packing");
    irq_mask_a: assert property (irq |-> $past(mask_sh) != 6'h00) else $error("irq while masked");
    irq_rise_a: assert property ($rose(irq) |-> $past(apply_wr, 3) || $past(irq_wr, 2))
        else $error("irq rose without cause");
    irq_fall_a: assert property ($fell(irq) |-> $past(irq_wr, 2)) else $error("latched alarm lost");
endmodule
`default_nettype wire

// ### verification/ciac_switch_model.sv
/*
 Switches and sensors on the eight input pins.
 Assumes the bench names the wanted contact levels.
*/
`timescale 1ns/1ps
`default_nettype none
module ciac_switch_model (
    input wire logic pclk,
    input wire logic [7:0] want,
    output var logic [7:0] pin_in
);
    // ==========================================
    // Contacts move just after an edge, as synchronous field wiring
    initial pin_in = 8'h00;
    always @(posedge pclk) begin
        pin_in <= want;
    end
endmodule
`default_nettype wire

// ### verification/control_input_assign_check_test.sv
/*
 Bench for ciac_top: APB master, switch model, assignment table.
 Assumes a short base period so read cycles stay brief.
*/
`timescale 1ns/1ps
`default_nettype none
module control_input_assign_check_test;
    localparam int BASE = 10;
    typedef struct packed {logic [2:0] pa; logic [23:0] va; logic [23:0] vb; logic [6:0] cfg; logic [5:0] al;} ciac_row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, force_mode_en = 0, err;
    logic [11:0] paddr = 12'h000;
    logic [1:0] force_mode = 2'h0;
    logic [31:0] pwdata = 32'h0000_0000, rd, prdata;
    logic pready, pslverr, irq;
    logic [7:0] want = 8'h00, pin_in;
    logic [15:0] func_state;
    logic [4:0] net_status;
    logic [11:0] ra [4] = '{12'h000, 12'h004, 12'h008, 12'h020};
    int bad_count = 0, n_tests = 0, n;
    // Only defined codes; pin b is always the second pin
    ciac_row_t rows [19] = '{
        '{3'h0, 24'h20_2020, 24'h00_0000, 7'h00, 6'h00}, '{3'h0, 24'h00_0020, 24'h00_0020, 7'h00, 6'h03},
        '{3'h0, 24'h00_0020, 24'h00_2000, 7'h00, 6'h01}, '{3'h0, 24'hA0_20A0, 24'h00_0000, 7'h00, 6'h04},
        '{3'h0, 24'h2E_2E2E, 24'h20_2020, 7'h00, 6'h03}, '{3'h0, 24'h2F_2F2F, 24'h21_2121, 7'h00, 6'h03},
        '{3'h0, 24'h2F_2F2F, 24'h27_2727, 7'h00, 6'h03}, '{3'h0, 24'h30_3030, 24'h2B_2B2B, 7'h00, 6'h03},
        '{3'h0, 24'h30_3030, 24'h23_2323, 7'h00, 6'h03}, '{3'h0, 24'h31_3131, 24'h03_0303, 7'h00, 6'h03},
        '{3'h0, 24'h32_3232, 24'h94_9494, 7'h00, 6'h03}, '{3'h0, 24'h00_0016, 24'h00_0000, 7'h10, 6'h08},
        '{3'h0, 24'h16_1616, 24'h00_0000, 7'h00, 6'h04}, '{3'h0, 24'h00_0014, 24'h00_0000, 7'h00, 6'h08},
        '{3'h0, 24'h00_0027, 24'h00_0000, 7'h00, 6'h08}, '{3'h0, 24'h00_0003, 24'h00_0000, 7'h00, 6'h08},
        '{3'h4, 24'h00_0020, 24'h00_0000, 7'h00, 6'h10}, '{3'h0, 24'h81_8181, 24'h00_0000, 7'h40, 6'h20},
        '{3'h0, 24'h81_8181, 24'h00_0000, 7'h44, 6'h00}};
    always #2 pclk = ~pclk;
    ciac_top #(.BASE_CYCLES(BASE)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .force_mode_en(force_mode_en), .force_mode(force_mode), .func_state(func_state),
        .net_status(net_status), .irq(irq));
    ciac_switch_model sw (.pclk(pclk), .want(want), .pin_in(pin_in));
    // ==========================================
    // Tasks
    task automatic conclude;
        if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // One transfer; a quiet cycle after it so psel never moves twice per step
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic wait_flip(output int k);
        logic v;
        v = func_state[11];
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (func_state[11] === v && k < 1000);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        tick(8);
        presetn <= 1'h1;
        tick(1);
        apb(12'h008, 1'h1, 32'h0000_003F);
        for (int i = 0; i < 19; i++) begin
            for (int p = 0; p < 8; p++) apb(12'h020 + 12'(4 * p), 1'h1, 32'h0);
            apb(12'h020 + 12'(4 * rows[i].pa), 1'h1, {8'h00, rows[i].va});
            apb(12'h024, 1'h1, {8'h00, rows[i].vb});
            apb(12'h000, 1'h1, {25'h0, rows[i].cfg | 7'h20});
            tick(3);
            apb(12'h004, 1'h0, 32'h0);
            chk(rd, {26'h0, rows[i].al});
            chk({31'h0, irq}, {31'h0, |rows[i].al});
            apb(12'h004, 1'h1, 32'h0000_003F);
        end
        // Second update after a toggle comes one whole read period later
        apb(12'h024, 1'h1, 32'h00AE_AEAE);
        apb(12'h028, 1'h1, 32'h0020_2020);
        tick(30);
        for (int c = 0; c < 4; c++) begin
            apb(12'h000, 1'h1, 32'(c));
            want <= want ^ 8'h02;
            wait_flip(n);
            want <= want ^ 8'h02;
            wait_flip(n);
            chk(32'(n), 32'(BASE << c));
            chk({31'h0, func_state[11]}, {31'h0, ~want[1]});
        end
        want <= want ^ 8'h04;
        tick(3);
        chk({31'h0, func_state[5]}, {31'h0, want[2]});
        apb(12'h024, 1'h1, 32'h0000_00AE);
        apb(12'h000, 1'h1, 32'h0000_0100);
        tick(200);
        chk({31'h0, func_state[11]}, 32'h0);
        force_mode_en <= 1'h1;
        tick(200);
        apb(12'h00C, 1'h0, 32'h0);
        chk({31'h0, rd[11]}, {31'h0, ~want[1]});
        chk({31'h0, rd[16]}, {31'h0, ~want[1] | want[2]});
        force_mode <= 2'h2;
        tick(200);
        chk({31'h0, func_state[11]}, 32'h0);
        force_mode_en <= 1'h0;
        // Masked alarm stays quiet until its mask bit opens
        apb(12'h008, 1'h1, 32'h0);
        apb(12'h020, 1'h1, 32'h0000_0020);
        apb(12'h024, 1'h1, 32'h0000_0020);
        apb(12'h000, 1'h1, 32'h0000_0020);
        tick(3);
        chk({31'h0, irq}, 32'h0);
        apb(12'h008, 1'h1, 32'h0000_0002);
        apb(12'h004, 1'h1, 32'h0000_0001);
        chk({31'h0, irq}, 32'h1);
        apb(12'h004, 1'h0, 32'h0);
        chk(rd, 32'h0000_0002);
        apb(12'h014, 1'h0, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(12'h03C, 1'h1, 32'hFFFF_FFFF);
        apb(12'h03C, 1'h0, 32'h0);
        chk(rd, 32'h00FF_FFFF);
        // Mid-run reset, then disabled pins must stay invisible
        presetn <= 1'h0;
        want <= 8'hFF;
        tick(2);
        chk({10'h0, irq, net_status, func_state}, 32'h0);
        presetn <= 1'h1;
        tick(100);
        chk({11'h0, net_status, func_state}, 32'h0);
        foreach (ra[i]) begin
            apb(ra[i], 1'h0, 32'h0);
            chk(rd, 32'h0);
        end
        conclude();
    end
    // Watchdog well beyond the expected run length
    initial begin
        repeat (40000) @(posedge pclk);
        bad_count++;
        conclude();
    end
endmodule
bind ciac_top ciac_chk #(.BASE_CYCLES(BASE_CYCLES)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .func_state(func_state), .net_status(net_status), .irq(irq));
`default_nettype wire
